/* File: logic/sdi_indexer.sv */
// Contract
// - Rising step edges are active; with double-edge mode both edges are active.
// - The direction level is sampled on each active step edge.
// - Resolution is full step or 2 to 256 microsteps per full step.
// - Direction low counts up, high counts down, by the resolution step size.
// - A sine table turns the counter into two coil current setpoints.
// - A strap level selects which serial control interface is active.
// - An SPI frame shifts a 40-bit command in and 40-bit status out.
// - The single-wire UART needs no programmed baud rate.
// - Current drops to a programmable hold level after a standstill delay.
// - Freewheeling or passive braking may replace hold current at standstill.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module sdi_indexer
    import sdi_pkg::*;
(
    // Clock and reset.
    input  wire logic                 CLOCK,
    input  wire logic                 RST_N,
    // Step and direction.
    input  wire logic                 STEP,
    input  wire logic                 DIR,
    // Interface strap.
    input  wire logic                 UART_EN,
    // SPI.
    input  wire logic                 SPI_SCK,
    input  wire logic                 SPI_CSN_N,
    input  wire logic                 SPI_SDI,
    output logic                      SPI_SDO,
    // Single-wire UART pin.
    input  wire logic                 SW_IN,
    output logic                      SW_OUT,
    output logic                      SW_OE_N,
    // AXI4-Lite slave.
    input  wire logic [AXI_AW-1:0]    AWADDR,
    input  wire logic                 AWVALID,
    output logic                      AWREADY,
    input  wire logic [31:0]          WDATA,
    input  wire logic [3:0]           WSTRB,
    input  wire logic                 WVALID,
    output logic                      WREADY,
    output logic [1:0]                BRESP,
    output logic                      BVALID,
    input  wire logic                 BREADY,
    input  wire logic [AXI_AW-1:0]    ARADDR,
    input  wire logic                 ARVALID,
    output logic                      ARREADY,
    output logic [31:0]               RDATA,
    output logic [1:0]                RRESP,
    output logic                      RVALID,
    input  wire logic                 RREADY,
    // Motor side.
    output logic signed [8:0]         COIL_A,
    output logic signed [8:0]         COIL_B,
    output logic                      STANDSTILL,
    output logic                      FREEWHEEL,
    output logic                      BRAKE,
    output logic                      IF_UART
);

    sdi_cfg_t          cfg;
    sdi_cur_t          cur_cfg;
    logic [31:0]       pdown;
    logic [PHASE_W-1:0] pos;
    logic              dir_last;
    logic              step_q;
    logic              step_act;
    logic [9:0]        inc;
    logic [9:0]        div_cnt;
    logic              tick;
    logic [7:0]        idle_ticks;
    logic [4:0]        cur;
    logic [3:0]        decay_cnt;
    sdi_coil_t         wave;
    logic              strap_done;
    logic              sw_q;
    logic [15:0]       low_cnt;
    logic [15:0]       bit_time;
    logic              sck_q;
    logic              csn_q;
    logic [39:0]       spi_sr;
    logic [31:0]       spi_reply;
    logic              spi_done;
    sdi_spi_t          spi_cmd;
    logic [39:0]       spi_load;
    logic              aw_ok;
    logic              w_ok;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wr_en;
    logic [AXI_AW-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;

    function automatic logic [9:0] step_size(input logic [3:0] mres);
        return (mres >= MRES_FULL) ? STEP_FULL : 10'(STEP_ONE << mres);
    endfunction

    function automatic logic mapped(input logic [AXI_AW-1:0] a);
        return a == ADDR_CONFIG || a == ADDR_CURRENT || a == ADDR_PDOWN ||
               a == ADDR_STATUS || a == ADDR_COIL || a == ADDR_BAUD;
    endfunction

    function automatic logic [31:0] read_word(input logic [AXI_AW-1:0] a);
        sdi_stat_t st;
        st            = '0;
        st.pos        = pos;
        st.standstill = STANDSTILL;
        st.dir        = dir_last;
        st.uart       = IF_UART;
        st.scale      = cur;
        unique case (a)
            ADDR_CONFIG:  return cfg;
            ADDR_CURRENT: return cur_cfg;
            ADDR_PDOWN:   return pdown;
            ADDR_STATUS:  return st;
            ADDR_COIL:    return {7'h00, COIL_B, 7'h00, COIL_A};
            ADDR_BAUD:    return {16'h0000, bit_time};
            default:      return 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return ((old & ~m) | (d & m)) & mask;
    endfunction

    function automatic logic signed [8:0] scale(input logic signed [8:0] w, input logic [4:0] c);
        logic signed [15:0] p;
        logic signed [15:0] k;
        // The gain is widened before the add, so a full-scale setting cannot wrap to a negative factor.
        k = $signed(16'({11'h000, c}) + 16'h0001);
        p = 16'(w) * k;
        return 9'(p >>> 5);
    endfunction

    // Step front end.
    assign step_act = (STEP & ~step_q) | (cfg.dedge & ~STEP & step_q);
    assign inc      = step_size(cfg.mres);

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            step_q   <= 1'b0;
            pos      <= '0;
            dir_last <= 1'b0;
        end
        else
        begin
            step_q <= STEP;
            if (step_act)
            begin
                dir_last <= DIR;
                pos      <= DIR ? PHASE_W'(pos - inc) : PHASE_W'(pos + inc);
            end
        end
    end

    // Slow tick for standstill timing; one enable pulse per TICK_CYCLES clocks.
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || tick)
            div_cnt <= '0;
        else
            div_cnt <= 10'(div_cnt + 10'h001);
    end
    assign tick = (div_cnt == 10'(TICK_CYCLES - 1));

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || step_act)
        begin
            idle_ticks <= '0;
            STANDSTILL <= 1'b0;
        end
        else if (tick && !STANDSTILL)
        begin
            // A delay lowered below the running count still expires at the next tick.
            if (idle_ticks >= pdown[7:0])
                STANDSTILL <= 1'b1;
            else
                idle_ticks <= 8'(idle_ticks + 8'h01);
        end
    end

    // Running current is taken at once; the fall to hold current is stepped to avoid a torque jerk.
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            cur       <= CURRENT_RST[4:0];
            decay_cnt <= '0;
        end
        else if (!STANDSTILL)
        begin
            cur       <= cur_cfg.irun;
            decay_cnt <= '0;
        end
        else if (tick && cfg.ss_mode == SS_HOLD)
        begin
            if (decay_cnt >= cur_cfg.decay)
            begin
                decay_cnt <= '0;
                if (cur > cur_cfg.ihold)
                    cur <= 5'(cur - 5'h01);
                else
                    cur <= cur_cfg.ihold;
            end
            else
                decay_cnt <= 4'(decay_cnt + 4'h1);
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            FREEWHEEL <= 1'b0;
            BRAKE     <= 1'b0;
        end
        else
        begin
            FREEWHEEL <= STANDSTILL && cfg.ss_mode == SS_FREE;
            BRAKE     <= STANDSTILL && cfg.ss_mode == SS_BRAKE;
        end
    end

    sdi_sine_rom u_rom
    (
        .phase (pos),
        .wave  (wave)
    );

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            COIL_A <= '0;
            COIL_B <= '0;
        end
        else
        begin
            COIL_A <= scale(wave.a, cur);
            COIL_B <= scale(wave.b, cur);
        end
    end

    // The strap is caught once after reset release and never again.
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            strap_done <= 1'b0;
            IF_UART    <= 1'b0;
        end
        else if (!strap_done)
        begin
            strap_done <= 1'b1;
            IF_UART    <= UART_EN;
        end
    end

    // Bit time is the shortest low pulse seen, so a host baud rate with bits under 65535 clocks is learned from traffic.
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            sw_q     <= 1'b1;
            low_cnt  <= '0;
            bit_time <= 16'hFFFF;
            SW_OUT   <= 1'b0;
            SW_OE_N  <= 1'b1;
        end
        else
        begin
            sw_q <= SW_IN;
            if (!IF_UART || SW_IN)
                low_cnt <= '0;
            else if (low_cnt != 16'hFFFF)
                low_cnt <= 16'(low_cnt + 16'h0001);
            if (IF_UART && SW_IN && !sw_q && low_cnt != 16'h0000 && low_cnt < bit_time)
                bit_time <= low_cnt;
        end
    end

    // SPI mode 3 sampled by the system clock; SCK must stay well below the clock rate.
    assign spi_done = !IF_UART && !csn_q && SPI_CSN_N;
    assign spi_cmd  = spi_sr;
    assign spi_load = {4'h0, STANDSTILL, 3'h0, spi_reply};

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            sck_q     <= 1'b1;
            csn_q     <= 1'b1;
            spi_sr    <= '0;
            spi_reply <= '0;
            SPI_SDO   <= 1'b0;
        end
        else
        begin
            sck_q <= SPI_SCK;
            csn_q <= SPI_CSN_N;
            if (!IF_UART && csn_q && !SPI_CSN_N)
            begin
                spi_sr  <= spi_load;
                SPI_SDO <= spi_load[39];
            end
            else if (!IF_UART && !SPI_CSN_N && SPI_SCK && !sck_q)
                spi_sr <= {spi_sr[38:0], SPI_SDI};
            else if (!IF_UART && !SPI_CSN_N && !SPI_SCK && sck_q)
                SPI_SDO <= spi_sr[39];
            if (spi_done)
                spi_reply <= spi_cmd.wr ? spi_cmd.data : read_word({spi_cmd.addr[5:0], 2'b00});
        end
    end

    // AXI4-Lite slave; a write from SPI in the same cycle as an AXI write is lost.
    always_comb
    begin
        wr_en   = 1'b0;
        wr_addr = aw_addr;
        wr_data = w_data;
        wr_strb = w_strb;
        if (aw_ok && w_ok && !BVALID)
            wr_en = 1'b1;
        else if (spi_done && spi_cmd.wr)
        begin
            wr_en   = 1'b1;
            wr_addr = {spi_cmd.addr[5:0], 2'b00};
            wr_data = spi_cmd.data;
            wr_strb = 4'hF;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            cfg     <= CONFIG_RST;
            cur_cfg <= CURRENT_RST;
            pdown   <= PDOWN_RST;
        end
        else if (wr_en)
        begin
            if (wr_addr == ADDR_CONFIG)
                cfg <= merge(cfg, wr_data, wr_strb, CONFIG_MASK);
            if (wr_addr == ADDR_CURRENT)
                cur_cfg <= merge(cur_cfg, wr_data, wr_strb, CURRENT_MASK);
            if (wr_addr == ADDR_PDOWN)
                pdown <= merge(pdown, wr_data, wr_strb, PDOWN_MASK);
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            aw_ok   <= 1'b0;
            w_ok    <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
            BVALID  <= 1'b0;
            BRESP   <= RESP_OKAY;
        end
        else
        begin
            if (AWVALID && AWREADY)
            begin
                aw_ok   <= 1'b1;
                aw_addr <= AWADDR;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY)
            begin
                w_ok   <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
                WREADY <= 1'b0;
            end
            if (aw_ok && w_ok && !BVALID)
            begin
                aw_ok  <= 1'b0;
                w_ok   <= 1'b0;
                BVALID <= 1'b1;
                BRESP  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (BVALID && BREADY)
            begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= '0;
            RRESP   <= RESP_OKAY;
        end
        else if (ARVALID && ARREADY)
        begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= read_word(ARADDR);
            RRESP   <= mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (RVALID && RREADY)
        begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    step_up_a:     assert property (step_act && !DIR |=> pos == PHASE_W'($past(pos) + $past(inc)))
        else $error("forward step did not add the step size");
    step_down_a:   assert property (step_act && DIR |=> pos == PHASE_W'($past(pos) - $past(inc)))
        else $error("reverse step did not subtract the step size");
    single_edge_a: assert property ($fell(STEP) && !cfg.dedge |=> $stable(pos))
        else $error("falling edge moved the counter in single-edge mode");
    dual_edge_a:   assert property ($fell(STEP) && cfg.dedge |=> !$stable(pos))
        else $error("falling edge ignored in double-edge mode");
    dir_sample_a:  assert property (step_act |=> dir_last == $past(DIR))
        else $error("direction not sampled on the step edge");
    full_step_a:   assert property (step_act && cfg.mres == MRES_FULL |=> pos[7:0] == $past(pos[7:0]))
        else $error("full step changed the microstep position");
    zero_sine_a:   assert property ((pos == 10'h000) [*3] |-> COIL_A == 9'h000 && COIL_B > 0)
        else $error("coil setpoints wrong at phase zero");
    strap_hold_a:  assert property (strap_done |=> $stable(IF_UART))
        else $error("interface selection changed after reset");
    spi_shift_a:   assert property (!IF_UART && !SPI_CSN_N && $rose(SPI_SCK) && !csn_q |=> spi_sr[0] == $past(SPI_SDI))
        else $error("SPI bit not shifted in on rising clock");
    baud_learn_a:  assert property (IF_UART && SW_IN && !sw_q && low_cnt != 0 && low_cnt < bit_time
                                    |=> bit_time == $past(low_cnt))
        else $error("UART bit time not learned");
    step_wake_a:   assert property (step_act |=> !STANDSTILL ##1 cur == $past(cur_cfg.irun))
        else $error("step did not restore run current");
    free_a:        assert property (FREEWHEEL || BRAKE |-> $past(STANDSTILL) && !(FREEWHEEL && BRAKE))
        else $error("standstill option active while moving");

    step_fwd_c:   cover property (step_act && !DIR);
    step_dedge_c: cover property ($fell(STEP) && cfg.dedge && DIR);
    stand_c:      cover property ($rose(STANDSTILL) && cfg.ss_mode == SS_HOLD);
    spi_frame_c:  cover property (spi_done && spi_cmd.wr);

endmodule

/* File: logic/sdi_pkg.sv */
package sdi_pkg;

    // Phase counter covers one electrical period of four quarter waves.
    localparam int          PHASE_W       = 10;
    localparam int          AXI_AW        = 8;
    localparam logic [3:0]  MRES_FULL     = 4'h8;
    localparam logic [9:0]  STEP_ONE      = 10'h001;
    localparam logic [9:0]  STEP_FULL     = 10'h100;
    localparam logic [9:0]  QUARTER       = 10'h100;
    localparam logic [5:0]  QUARTER_LAST  = 6'h20;
    localparam int          TICK_CYCLES   = 1024;

    // Register byte offsets.
    localparam logic [7:0]  ADDR_CONFIG   = 8'h00;
    localparam logic [7:0]  ADDR_CURRENT  = 8'h04;
    localparam logic [7:0]  ADDR_PDOWN    = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    localparam logic [7:0]  ADDR_COIL     = 8'h10;
    localparam logic [7:0]  ADDR_BAUD     = 8'h14;

    // Reset values and writable-bit masks.
    localparam logic [31:0] CONFIG_RST    = 32'h0000_0000;
    localparam logic [31:0] CURRENT_RST   = 32'h0001_101F;
    localparam logic [31:0] PDOWN_RST     = 32'h0000_0014;
    localparam logic [31:0] CONFIG_MASK   = 32'h0000_007F;
    localparam logic [31:0] CURRENT_MASK  = 32'h000F_1F1F;
    localparam logic [31:0] PDOWN_MASK    = 32'h0000_00FF;

    // Standstill options.
    localparam logic [1:0]  SS_HOLD       = 2'h0;
    localparam logic [1:0]  SS_FREE       = 2'h1;
    localparam logic [1:0]  SS_BRAKE      = 2'h2;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic [24:0] pad;
        logic [1:0]  ss_mode;
        logic        dedge;
        logic [3:0]  mres;
    } sdi_cfg_t;

    typedef struct packed {
        logic [11:0] pad2;
        logic [3:0]  decay;
        logic [2:0]  pad1;
        logic [4:0]  ihold;
        logic [2:0]  pad0;
        logic [4:0]  irun;
    } sdi_cur_t;

    typedef struct packed {
        logic [2:0]  pad2;
        logic [4:0]  scale;
        logic [4:0]  pad1;
        logic        uart;
        logic        dir;
        logic        standstill;
        logic [5:0]  pad0;
        logic [9:0]  pos;
    } sdi_stat_t;

    typedef struct packed {
        logic        wr;
        logic [6:0]  addr;
        logic [31:0] data;
    } sdi_spi_t;

    typedef struct packed {
        logic signed [8:0] a;
        logic signed [8:0] b;
    } sdi_coil_t;

    // Quarter sine in 33 points, 8 microsteps apart; entry 0 is the low byte.
    localparam logic [32:0][7:0] SINE_Q = {
        8'hF8, 8'hF8, 8'hF7, 8'hF6, 8'hF4, 8'hF1, 8'hED, 8'hEA, 8'hE5, 8'hE0, 8'hDB,
        8'hD5, 8'hCE, 8'hC7, 8'hC0, 8'hB8, 8'hAF, 8'hA6, 8'h9D, 8'h94, 8'h8A, 8'h7F,
        8'h75, 8'h6A, 8'h5F, 8'h53, 8'h48, 8'h3C, 8'h30, 8'h24, 8'h18, 8'h0C, 8'h00};

endpackage

/* File: logic/sdi_sine_rom.sv */
`timescale 1ns/100ps
module sdi_sine_rom
    import sdi_pkg::*;
(
    // Phase in.
    input  wire logic [PHASE_W-1:0] phase,
    // Coil setpoints out.
    output sdi_coil_t               wave
);

    // Table points are interpolated linearly, which keeps the table small at a cost below one LSB.
    function automatic logic signed [8:0] wave_at(input logic [PHASE_W-1:0] ph);
        logic [8:0]  q;
        logic [5:0]  idx;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [10:0] mag;
        q   = ph[8] ? 9'(9'h100 - {1'b0, ph[7:0]}) : {1'b0, ph[7:0]};
        idx = q[8:3];
        lo  = SINE_Q[idx];
        hi  = (idx == QUARTER_LAST) ? lo : SINE_Q[6'(idx + 6'h01)];
        mag = {3'h0, lo} + 11'(({3'h0, 8'(hi - lo)} * {8'h00, q[2:0]}) >> 3);
        return ph[9] ? 9'(-$signed({1'b0, mag[7:0]})) : $signed({1'b0, mag[7:0]});
    endfunction

    always_comb
    begin
        wave.a = wave_at(phase);
        wave.b = wave_at(PHASE_W'(phase + QUARTER));
    end

endmodule

/* File: verification/sdi_step_src.sv */
`timescale 1ns/100ps
module sdi_step_src (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Request.
    input  wire logic       go,
    input  wire logic       dir_req,
    input  wire logic [7:0] edges,
    // Step pins.
    output logic            step,
    output logic            dir,
    output logic            busy
);
    logic [7:0] left;
    logic [1:0] hold;

    // Every level lasts three cycles, so a slow controller never outruns the sampler.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            {left, hold, step, dir, busy} <= '0;
        else if (go && !busy)
            {left, hold, dir, busy} <= {edges, 2'h2, dir_req, 1'b1};
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
        else if (left != 8'h00)
            {left, hold, step} <= {left - 8'h01, 2'h2, ~step};
        else
            busy <= 1'b0;
    end
endmodule

/* File: verification/sdi_tb.sv */
`timescale 1ns/100ps
module testbench
    import sdi_pkg::*;
;
    logic              CLOCK, RST_N, STEP, DIR, UART_EN, SW_IN, SW_OUT, SW_OE_N;
    logic              SPI_SCK, SPI_CSN_N, SPI_SDI, SPI_SDO, go, dreq, busy;
    logic              AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic              ARVALID, ARREADY, RVALID, RREADY;
    logic              STANDSTILL, FREEWHEEL, BRAKE, IF_UART;
    logic [7:0]        AWADDR, ARADDR, edges;
    logic [31:0]       WDATA, RDATA, d;
    logic [3:0]        WSTRB;
    logic [1:0]        BRESP, RRESP, r;
    logic signed [8:0] COIL_A, COIL_B;
    logic [39:0]       rx;
    int                num_errors, checked, p;

    sdi_indexer dut (.*);
    sdi_step_src src (.clk(CLOCK), .rst_n(RST_N), .go(go), .dir_req(dreq), .edges(edges),
                      .step(STEP), .dir(DIR), .busy(busy));

    initial
    begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic hang(input string nm);
        chk(nm, 32'h1, 32'h0);
        final_report();
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLOCK);
        {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, v, 3'h7};
        for (p = 0; p < 60; p++)
        begin
            @(posedge CLOCK);
            if (AWREADY)
                AWVALID <= 1'b0;
            if (WREADY)
                WVALID <= 1'b0;
            if (BVALID)
                break;
        end
        if (p >= 60)
            hang("axi_write");
        r = BRESP;
        BREADY <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge CLOCK);
        {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
        for (p = 0; p < 60 && !RVALID; p++)
        begin
            @(posedge CLOCK);
            if (ARREADY)
                ARVALID <= 1'b0;
        end
        if (p >= 60)
            hang("axi_read");
        {d, r} = {RDATA, RRESP};
        RREADY <= 1'b0;
    endtask

    task automatic stp(input logic dr, input logic [7:0] e);
        @(posedge CLOCK);
        {go, dreq, edges} <= {1'b1, dr, e};
        @(posedge CLOCK);
        go <= 1'b0;
        @(posedge CLOCK);
        for (p = 0; busy; p++)
        begin
            @(posedge CLOCK);
            if (p > 1000)
                hang("step_done");
        end
    endtask

    task automatic pos_is(input string nm, input logic [9:0] e);
        axi_rd(ADDR_STATUS);
        chk(nm, {22'h0, e}, {22'h0, d[9:0]});
    endtask

    task automatic spi(input logic [39:0] tx);
        @(posedge CLOCK);
        SPI_CSN_N <= 1'b0;
        for (int i = 39; i >= 0; i--)
        begin
            repeat (3) @(posedge CLOCK);
            {SPI_SCK, SPI_SDI} <= {1'b0, tx[i]};
            repeat (3) @(posedge CLOCK);
            SPI_SCK <= 1'b1;
            rx[i] = SPI_SDO;
        end
        repeat (3) @(posedge CLOCK);
        SPI_CSN_N <= 1'b1;
        repeat (4) @(posedge CLOCK);
    endtask

    task automatic t_regs();
        axi_rd(ADDR_CONFIG);
        chk("config_rst", CONFIG_RST, d);
        axi_rd(ADDR_CURRENT);
        chk("current_rst", CURRENT_RST, d);
        axi_rd(ADDR_PDOWN);
        chk("pdown_rst", PDOWN_RST, d);
        axi_rd(ADDR_BAUD);
        chk("baud_rst", 32'h0000_FFFF, d);
        axi_rd(8'h18);
        chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_wr(ADDR_CONFIG, 32'hFFFF_FFFF);
        axi_rd(ADDR_CONFIG);
        chk("config_mask", CONFIG_MASK, d);
        axi_wr(ADDR_CONFIG, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_steps();
        logic [9:0] e;
        stp(1'b0, 8'h06);
        pos_is("pos_up", 10'h003);
        stp(1'b1, 8'h0A);
        pos_is("pos_wrap", 10'h3FE);
        e = 10'h3FE;
        for (int m = 1; m <= 8; m++)
        begin
            axi_wr(ADDR_CONFIG, 32'(m));
            stp(1'b0, 8'h02);
            e = e + ((m >= 8) ? STEP_FULL : (STEP_ONE << m));
            pos_is("pos_res", e);
        end
        axi_wr(ADDR_CONFIG, 32'h10);
        stp(1'b0, 8'h08);
        pos_is("pos_dedge", e + 10'h008);
        axi_wr(ADDR_CONFIG, 32'h0);
        stp(1'b1, 8'h08);
        pos_is("pos_back", 10'h200);
        repeat (3) @(posedge CLOCK);
        chk("coil_a", 32'h0, 32'(COIL_A));
        chk("coil_b", -32'sd248, 32'(COIL_B));
        $display("test steps done");
    endtask

    task automatic t_spi();
        spi({8'h82, 32'h0000_0033});
        spi({8'h02, 32'h0});
        chk("spi_echo", 32'h33, rx[31:0]);
        spi({8'h02, 32'h0});
        chk("spi_read", 32'h33, rx[31:0]);
        axi_rd(ADDR_PDOWN);
        chk("spi_write", 32'h33, d);
        $display("test spi done");
    endtask

    task automatic t_still();
        axi_wr(ADDR_CURRENT, 32'h0000_1E1F);
        axi_wr(ADDR_PDOWN, 32'h0);
        for (p = 0; !STANDSTILL; p++)
        begin
            @(posedge CLOCK);
            if (p > 3000)
                hang("standstill");
        end
        repeat (2100) @(posedge CLOCK);
        axi_rd(ADDR_STATUS);
        chk("hold_scale", 32'h1E, 32'(d[28:24]));
        axi_wr(ADDR_CONFIG, 32'h20);
        repeat (3) @(posedge CLOCK);
        chk("freewheel", 32'h2, {30'h0, FREEWHEEL, BRAKE});
        axi_wr(ADDR_CONFIG, 32'h40);
        repeat (3) @(posedge CLOCK);
        chk("brake", 32'h1, {30'h0, FREEWHEEL, BRAKE});
        axi_wr(ADDR_PDOWN, PDOWN_RST);
        stp(1'b0, 8'h02);
        chk("moving", 32'h0, {29'h0, STANDSTILL, FREEWHEEL, BRAKE});
        axi_rd(ADDR_STATUS);
        chk("run_scale", 32'h1F, 32'(d[28:24]));
        $display("test standstill done");
    endtask

    task automatic t_strap();
        RST_N <= 1'b0;
        UART_EN <= 1'b1;
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLOCK);
        chk("if_uart", 32'h1, {31'h0, IF_UART});
        chk("sw_oe_n", 32'h1, {31'h0, SW_OE_N});
        chk("sw_out", 32'h0, {31'h0, SW_OUT});
        SW_IN <= 1'b0;
        repeat (5) @(posedge CLOCK);
        SW_IN <= 1'b1;
        repeat (3) @(posedge CLOCK);
        axi_rd(ADDR_BAUD);
        chk("baud_learn", 32'h5, d);
        $display("test strap done");
    endtask

    initial
    begin
        {RST_N, go, dreq, edges, UART_EN, SPI_SDI, num_errors, checked} = '0;
        {SW_IN, SPI_SCK, SPI_CSN_N, WSTRB} = 7'h7F;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        t_regs();
        t_steps();
        t_spi();
        t_still();
        t_strap();
        final_report();
    end
endmodule
